//--- include/mhc_defs.vh
// Register map, field positions and reset values of the card host register bank
`ifndef MHC_DEFS_VH
`define MHC_DEFS_VH

// ----------------------------------------------------------------------------
// Address width and register offsets
// ----------------------------------------------------------------------------
`define MHC_AW          12
`define MHC_OFF_CTRL    12'h000
`define MHC_OFF_MODE    12'h004
`define MHC_OFF_DTO     12'h008
`define MHC_OFF_CARD    12'h00c
`define MHC_OFF_ARG     12'h010
`define MHC_OFF_CMD     12'h014
`define MHC_OFF_BLK     12'h018
`define MHC_OFF_CSTO    12'h01c
`define MHC_OFF_RSP0    12'h020
`define MHC_OFF_RSP1    12'h024
`define MHC_OFF_RSP2    12'h028
`define MHC_OFF_RSP3    12'h02c
`define MHC_OFF_RXD     12'h030
`define MHC_OFF_TXD     12'h034
`define MHC_OFF_STAT    12'h040
`define MHC_OFF_IEN     12'h044
`define MHC_OFF_IDIS    12'h048
`define MHC_OFF_IMASK   12'h04c
`define MHC_OFF_DMA     12'h050
`define MHC_OFF_CFG     12'h054
`define MHC_OFF_WPMODE  12'h0e4
`define MHC_OFF_WPSTAT  12'h0e8

// ----------------------------------------------------------------------------
// Control register bits
// ----------------------------------------------------------------------------
`define MHC_CR_IFACE_ON   0
`define MHC_CR_IFACE_OFF  1
`define MHC_CR_PWS_ON     2
`define MHC_CR_PWS_OFF    3
`define MHC_CR_SRST       7

// ----------------------------------------------------------------------------
// Mode, timeout, card and block register fields
// ----------------------------------------------------------------------------
`define MHC_MR_DIV_LSB    0
`define MHC_MR_DIV_MSB    7
`define MHC_MR_PWS_LSB    8
`define MHC_MR_PWS_MSB    10
`define MHC_MR_RDGUARD    11
`define MHC_MR_WRGUARD    12
`define MHC_MR_FORCE_BYTE_MODE      13
`define MHC_MR_PAD_FILL_SELECT       14
`define MHC_MR_ODD        16
`define MHC_MR_MASK       32'h0001_7fff
`define MHC_DTO_CYC_LSB   0
`define MHC_DTO_CYC_MSB   3
`define MHC_DTO_MUL_LSB   4
`define MHC_DTO_MUL_MSB   6
`define MHC_DTO_MASK      32'h0000_007f
`define MHC_CARD_MASK     32'h0000_00c3
`define MHC_BLK_FB_MASK   32'hfffc_ffff

// ----------------------------------------------------------------------------
// Status and write-lock fields
// ----------------------------------------------------------------------------
`define MHC_SR_RST        32'h0000_c0e5
`define MHC_SR_DATA_TIMEOUT_ERROR       22
`define MHC_WPM_EN        0
`define MHC_WPS_VIOL      0
`define MHC_WPS_SRC_LSB   8
`define MHC_WPS_SRC_MSB   15
`define MHC_ZERO32        32'h0000_0000

`endif

//--- hdl/mhc_clkgen.v
// Card clock divider with power-save prescaler and guard stall
`timescale 1ns/1ps
module mhc_clkgen (
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       srst,
  input  wire       run,
  input  wire       stop,
  input  wire [8:0] div,
  input  wire       pws_on,
  input  wire [2:0] pws_div,
  output reg        card_clk_q
);

  // --------------------------------------------------------------------------
  // Ratio and prescale
  // --------------------------------------------------------------------------
  wire [9:0] ratio   = {1'b0, div} + 10'h002;
  wire [9:0] half    = {1'b0, ratio[9:1]};
  // Power save stretches every divider step to (2^p)+1 master cycles
  wire [7:0] pre_top = pws_on ? (8'h01 << pws_div) : 8'h00;
  reg  [7:0] pre_q;
  reg  [9:0] cnt_q;
  wire       tick    = (pre_q >= pre_top);
  wire       wrap    = (cnt_q >= ratio - 10'h001);
  wire [9:0] cnt_nx  = wrap ? 10'h000 : cnt_q + 10'h001;

  // --------------------------------------------------------------------------
  // Divider
  // --------------------------------------------------------------------------
  // Stall freezes the level rather than forcing low, so no runt pulse reaches the card
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_q      <= 8'h00;
      cnt_q      <= 10'h000;
      card_clk_q <= 1'b0;
    end else if (srst || !run) begin
      pre_q      <= 8'h00;
      cnt_q      <= 10'h000;
      card_clk_q <= 1'b0;
    end else if (!stop) begin
      pre_q <= tick ? 8'h00 : pre_q + 8'h01;
      if (tick) begin
        cnt_q      <= cnt_nx;
        card_clk_q <= (cnt_nx >= half);
      end
    end
  end

endmodule

//--- hdl/mhc_dtimer.v
// Data timeout counter between block transfers
`timescale 1ns/1ps
module mhc_dtimer #(
  parameter TMR_W = 24
) (
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       srst,
  input  wire       active,
  input  wire       restart,
  input  wire [3:0] cyc,
  input  wire [2:0] mul,
  output reg        expire_q
);

  // --------------------------------------------------------------------------
  // Limit
  // --------------------------------------------------------------------------
  reg  [4:0]       sh;
  reg  [TMR_W-1:0] cnt_q;
  reg              done_q;
  wire [TMR_W-1:0] limit = {{(TMR_W-4){1'b0}}, cyc} << sh;

  always @* begin
    case (mul)
      3'h0:    sh = 5'h00;
      3'h1:    sh = 5'h04;
      3'h2:    sh = 5'h07;
      3'h3:    sh = 5'h08;
      3'h4:    sh = 5'h0a;
      3'h5:    sh = 5'h0c;
      3'h6:    sh = 5'h10;
      default: sh = 5'h14;
    endcase
  end

  // --------------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------------
  // Fires once per gap; stays quiet until the next block or re-arm
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q    <= {TMR_W{1'b0}};
      done_q   <= 1'b0;
      expire_q <= 1'b0;
    end else if (srst || !active || restart) begin
      cnt_q    <= {TMR_W{1'b0}};
      done_q   <= 1'b0;
      expire_q <= 1'b0;
    end else if (!done_q && cnt_q >= limit) begin
      done_q   <= 1'b1;
      expire_q <= 1'b1;
    end else begin
      if (!done_q) begin
        cnt_q <= cnt_q + {{(TMR_W-1){1'b0}}, 1'b1};
      end
      expire_q <= 1'b0;
    end
  end

endmodule

//--- hdl/mhc_regs.v
// Card host configuration register bank with AHB-Lite slave
// Contract
// - Enable bit turns interface on unless disabled
// - Disable bit turns interface off
// - Power save on unless off also written
// - Soft reset bit resets whole controller
// - Card clock is master over divider plus two
// - Odd bit is divider least significant bit
// - Power save divides further by 2^p plus one
// - Read guard stalls clock on full FIFO
// - Write guard stalls clock on FIFO condition
// - Force byte allows non-multiple-of-four blocks
// - Pad select gives fill 0x00 or 0xff
// - Protected registers writable only when unlocked
// - Timeout is cycles times multiplier
// - Multiplier code selects one of eight factors
// - Expired timeout sets status error flag
// - Response readable repeated or at consecutive words
// - Locked write sets violation, source; read clears
`include "mhc_defs.vh"
`timescale 1ns/1ps
module mhc_regs #(
  parameter TMR_W = 24
) (
  input  wire                hclk,
  input  wire                hresetn,
  input  wire                hsel,
  input  wire [`MHC_AW-1:0]  haddr,
  input  wire [1:0]          htrans,
  input  wire                hwrite,
  input  wire [2:0]          hsize,
  input  wire [31:0]         hwdata,
  input  wire                hready,
  output reg  [31:0]         hrdata,
  output reg                 hreadyout,
  output reg                 hresp,
  input  wire                xfer_read,
  input  wire                xfer_write,
  input  wire                fifo_full,
  input  wire                block_done,
  input  wire                rsp_load,
  input  wire [127:0]        rsp_data,
  output wire                card_clk,
  output reg                 iface_on_q,
  output reg                 powersave_on_q,
  output reg  [1:0]          card_slot_select_q,
  output reg  [1:0]          card_bus_width_q,
  output reg                 force_byte_mode_q,
  output reg  [7:0]          pad_byte_q,
  output reg                 data_timeout_error_q
);

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  reg  [31:0]        mode_q;
  reg  [31:0]        dto_q;
  reg  [31:0]        card_q;
  reg  [31:0]        arg_q;
  reg  [31:0]        blk_q;
  reg  [31:0]        csto_q;
  reg  [31:0]        dma_q;
  reg  [31:0]        cfg_q;
  reg                write_lock_enable_q;
  reg                write_lock_violation_q;
  reg  [7:0]         viol_src_q;
  reg  [31:0]        rsp_q [0:3];
  reg  [1:0]         rsp_ptr_q;

  // --------------------------------------------------------------------------
  // Bus phases
  // --------------------------------------------------------------------------
  reg                wr_pend_q;
  reg  [`MHC_AW-1:0] wr_addr_q;
  reg  [31:0]        rd_d;
  wire               addr_ph = hsel && hready && htrans[1];
  wire               rd_req  = addr_ph && !hwrite;
  wire [`MHC_AW-1:0] rd_addr = {haddr[`MHC_AW-1:2], 2'b00};
  wire               wr_ph   = wr_pend_q;
  wire               rd_rsp0 = rd_req && (rd_addr == `MHC_OFF_RSP0);
  wire               rd_stat = rd_req && (rd_addr == `MHC_OFF_STAT);
  wire               rd_wps  = rd_req && (rd_addr == `MHC_OFF_WPSTAT);

  // Registers guarded by the write lock
  reg                prot_hit;
  always @* begin
    case (wr_addr_q)
      `MHC_OFF_MODE: prot_hit = 1'b1;
      `MHC_OFF_DTO:  prot_hit = 1'b1;
      `MHC_OFF_CARD: prot_hit = 1'b1;
      `MHC_OFF_CSTO: prot_hit = 1'b1;
      `MHC_OFF_DMA:  prot_hit = 1'b1;
      `MHC_OFF_CFG:  prot_hit = 1'b1;
      default:       prot_hit = 1'b0;
    endcase
  end

  wire wr_ok   = wr_ph && !(prot_hit && write_lock_enable_q);
  wire wr_viol = wr_ph && prot_hit && write_lock_enable_q;
  wire wr_ctrl = wr_ph && (wr_addr_q == `MHC_OFF_CTRL);
  // Soft reset acts in the data phase of its own write
  wire srst    = wr_ctrl && hwdata[`MHC_CR_SRST];

  // --------------------------------------------------------------------------
  // AHB-Lite handshake
  // --------------------------------------------------------------------------
  // Zero wait states; hsize ignored since only whole words are mapped
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= {`MHC_AW{1'b0}};
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        wr_pend_q <= addr_ph && hwrite;
        wr_addr_q <= {haddr[`MHC_AW-1:2], 2'b00};
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  always @* begin
    case (rd_addr)
      `MHC_OFF_MODE:   rd_d = mode_q;
      `MHC_OFF_DTO:    rd_d = dto_q;
      `MHC_OFF_CARD:   rd_d = card_q;
      `MHC_OFF_ARG:    rd_d = arg_q;
      `MHC_OFF_BLK:    rd_d = blk_q;
      `MHC_OFF_CSTO:   rd_d = csto_q;
      `MHC_OFF_RSP0:   rd_d = rsp_q[rsp_ptr_q];
      `MHC_OFF_RSP1:   rd_d = rsp_q[rd_addr[3:2]];
      `MHC_OFF_RSP2:   rd_d = rsp_q[rd_addr[3:2]];
      `MHC_OFF_RSP3:   rd_d = rsp_q[rd_addr[3:2]];
      `MHC_OFF_STAT: begin
        rd_d = `MHC_SR_RST;
        rd_d[`MHC_SR_DATA_TIMEOUT_ERROR] = data_timeout_error_q;
      end
      `MHC_OFF_DMA:    rd_d = dma_q;
      `MHC_OFF_CFG:    rd_d = cfg_q;
      `MHC_OFF_WPMODE: begin
        rd_d = `MHC_ZERO32;
        rd_d[`MHC_WPM_EN] = write_lock_enable_q;
      end
      `MHC_OFF_WPSTAT: begin
        rd_d = `MHC_ZERO32;
        rd_d[`MHC_WPS_VIOL] = write_lock_violation_q;
        rd_d[`MHC_WPS_SRC_MSB:`MHC_WPS_SRC_LSB] = viol_src_q;
      end
      default:         rd_d = `MHC_ZERO32;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `MHC_ZERO32;
    end else if (rd_req) begin
      hrdata <= rd_d;
    end
  end

  // --------------------------------------------------------------------------
  // Control register actions
  // --------------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      iface_on_q     <= 1'b0;
      powersave_on_q <= 1'b0;
    end else if (srst) begin
      iface_on_q     <= 1'b0;
      powersave_on_q <= 1'b0;
    end else if (wr_ctrl) begin
      if (hwdata[`MHC_CR_IFACE_OFF]) begin
        iface_on_q <= 1'b0;
      end else if (hwdata[`MHC_CR_IFACE_ON]) begin
        iface_on_q <= 1'b1;
      end
      // Divider of zero in power save is not rejected here
      if (hwdata[`MHC_CR_PWS_OFF]) begin
        powersave_on_q <= 1'b0;
      end else if (hwdata[`MHC_CR_PWS_ON]) begin
        powersave_on_q <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= `MHC_ZERO32;
      dto_q  <= `MHC_ZERO32;
      card_q <= `MHC_ZERO32;
      arg_q  <= `MHC_ZERO32;
      blk_q  <= `MHC_ZERO32;
      csto_q <= `MHC_ZERO32;
      dma_q  <= `MHC_ZERO32;
      cfg_q  <= `MHC_ZERO32;
      write_lock_enable_q <= 1'b0;
    end else if (srst) begin
      mode_q <= `MHC_ZERO32;
      dto_q  <= `MHC_ZERO32;
      card_q <= `MHC_ZERO32;
      arg_q  <= `MHC_ZERO32;
      blk_q  <= `MHC_ZERO32;
      csto_q <= `MHC_ZERO32;
      dma_q  <= `MHC_ZERO32;
      cfg_q  <= `MHC_ZERO32;
      write_lock_enable_q <= 1'b0;
    end else if (wr_ok) begin
      case (wr_addr_q)
        `MHC_OFF_MODE:   mode_q <= hwdata & `MHC_MR_MASK;
        `MHC_OFF_DTO:    dto_q  <= hwdata & `MHC_DTO_MASK;
        `MHC_OFF_CARD:   card_q <= hwdata & `MHC_CARD_MASK;
        `MHC_OFF_ARG:    arg_q  <= hwdata;
        // Without byte mode the length stays a whole number of words
        `MHC_OFF_BLK:    blk_q  <= force_byte_mode_q ? hwdata : (hwdata & `MHC_BLK_FB_MASK);
        `MHC_OFF_CSTO:   csto_q <= hwdata;
        `MHC_OFF_DMA:    dma_q  <= hwdata;
        `MHC_OFF_CFG:    cfg_q  <= hwdata;
        `MHC_OFF_WPMODE: write_lock_enable_q <= hwdata[`MHC_WPM_EN];
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Decoded mode outputs
  // --------------------------------------------------------------------------
  // Registered copies keep every top-level output on a flop
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      force_byte_mode_q  <= 1'b0;
      pad_byte_q         <= 8'h00;
      card_slot_select_q <= 2'h0;
      card_bus_width_q   <= 2'h0;
    end else begin
      force_byte_mode_q  <= mode_q[`MHC_MR_FORCE_BYTE_MODE];
      pad_byte_q         <= mode_q[`MHC_MR_PAD_FILL_SELECT] ? 8'hff : 8'h00;
      card_slot_select_q <= card_q[1:0];
      card_bus_width_q   <= card_q[7:6];
    end
  end

  // --------------------------------------------------------------------------
  // Write-lock violation
  // --------------------------------------------------------------------------
  // A violation in the same cycle as the clearing read survives it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      write_lock_violation_q <= 1'b0;
      viol_src_q             <= 8'h00;
    end else if (srst) begin
      write_lock_violation_q <= 1'b0;
      viol_src_q             <= 8'h00;
    end else if (wr_viol) begin
      write_lock_violation_q <= 1'b1;
      viol_src_q             <= wr_addr_q[9:2];
    end else if (rd_wps) begin
      write_lock_violation_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Response words
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_rsp
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          rsp_q[gi] <= `MHC_ZERO32;
        end else if (srst) begin
          rsp_q[gi] <= `MHC_ZERO32;
        end else if (rsp_load) begin
          rsp_q[gi] <= rsp_data[127-32*gi -: 32];
        end
      end
    end
  endgenerate

  // Repeated reads at the first word walk through the response
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rsp_ptr_q <= 2'h0;
    end else if (srst || rsp_load) begin
      rsp_ptr_q <= 2'h0;
    end else if (rd_rsp0) begin
      rsp_ptr_q <= rsp_ptr_q + 2'h1;
    end
  end

  // --------------------------------------------------------------------------
  // Card clock
  // --------------------------------------------------------------------------
  wire guard_stop = fifo_full &&
                    ((mode_q[`MHC_MR_RDGUARD] && xfer_read) ||
                     (mode_q[`MHC_MR_WRGUARD] && xfer_write));

  mhc_clkgen u_clk (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .srst       (srst),
    .run        (iface_on_q),
    .stop       (guard_stop),
    .div        ({mode_q[`MHC_MR_DIV_MSB:`MHC_MR_DIV_LSB], mode_q[`MHC_MR_ODD]}),
    .pws_on     (powersave_on_q),
    .pws_div    (mode_q[`MHC_MR_PWS_MSB:`MHC_MR_PWS_LSB]),
    .card_clk_q (card_clk)
  );

  // --------------------------------------------------------------------------
  // Data timeout
  // --------------------------------------------------------------------------
  wire dto_expire;

  mhc_dtimer #(
    .TMR_W (TMR_W)
  ) u_dto (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .srst     (srst),
    .active   (iface_on_q && (xfer_read || xfer_write)),
    .restart  (block_done),
    .cyc      (dto_q[`MHC_DTO_CYC_MSB:`MHC_DTO_CYC_LSB]),
    .mul      (dto_q[`MHC_DTO_MUL_MSB:`MHC_DTO_MUL_LSB]),
    .expire_q (dto_expire)
  );

  // Expiry wins over a clearing status read in the same cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_timeout_error_q <= 1'b0;
    end else if (srst) begin
      data_timeout_error_q <= 1'b0;
    end else if (dto_expire) begin
      data_timeout_error_q <= 1'b1;
    end else if (rd_stat) begin
      data_timeout_error_q <= 1'b0;
    end
  end

endmodule

//--- hdl/mhc_unused_placeholder_none.v
// Intentionally empty module list
`timescale 1ns/1ps

//--- testbench/mhc_regs_chk.sv
// Control-bit and clock checker for the card host register bank
`include "mhc_defs.vh"
`timescale 1ns/1ps
module mhc_regs_chk #(
  parameter TMR_W = 24
) (
  input wire               hclk,
  input wire               hresetn,
  input wire               hsel,
  input wire [`MHC_AW-1:0] haddr,
  input wire [1:0]         htrans,
  input wire               hwrite,
  input wire [2:0]         hsize,
  input wire [31:0]        hwdata,
  input wire               hready,
  input wire [31:0]        hrdata,
  input wire               hreadyout,
  input wire               hresp,
  input wire               xfer_read,
  input wire               xfer_write,
  input wire               fifo_full,
  input wire               block_done,
  input wire               rsp_load,
  input wire [127:0]       rsp_data,
  input wire               card_clk,
  input wire               iface_on_q,
  input wire               powersave_on_q,
  input wire [1:0]         card_slot_select_q,
  input wire [1:0]         card_bus_width_q,
  input wire               force_byte_mode_q,
  input wire [7:0]         pad_byte_q,
  input wire               data_timeout_error_q
);
  // Data phase of a control write: hwdata is valid now
  reg wr_ctrl_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wr_ctrl_q <= 1'b0;
    else wr_ctrl_q <= hsel & hready & htrans[1] & hwrite & (haddr[11:2] == 10'h000);
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_off_wins: assert property (wr_ctrl_q && hwdata[1] |=> !iface_on_q)
    else $error("interface stayed on after disable");
  a_on_sets: assert property (wr_ctrl_q && hwdata[0] && !hwdata[1] && !hwdata[7] |=> iface_on_q)
    else $error("interface not enabled");
  a_on_cause: assert property ($changed(iface_on_q) |-> $past(wr_ctrl_q))
    else $error("interface state changed without control write");
  a_ps_off: assert property (wr_ctrl_q && hwdata[3] |=> !powersave_on_q)
    else $error("power save stayed on");
  a_ps_on: assert property (wr_ctrl_q && hwdata[2] && !hwdata[3] && !hwdata[7] |=> powersave_on_q)
    else $error("power save not entered");
  a_srst_clear: assert property (wr_ctrl_q && hwdata[7] |=> !iface_on_q && !powersave_on_q
    ##1 card_bus_width_q == 2'b00 && !force_byte_mode_q)
    else $error("soft reset left state behind");
  a_clk_idle: assert property (!iface_on_q && !$past(iface_on_q) && !$past(iface_on_q, 2) |-> !card_clk)
    else $error("card clock runs while interface off");
  a_pad_value: assert property (pad_byte_q == 8'h00 || pad_byte_q == 8'hff)
    else $error("pad byte not a legal fill");
  a_tmo_cause: assert property ($rose(data_timeout_error_q) |-> $past(iface_on_q && (xfer_read || xfer_write), 2))
    else $error("timeout flagged without active transfer");
endmodule
bind mhc_regs mhc_regs_chk #(.TMR_W(TMR_W)) u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
  .hwdata, .hready, .hrdata, .hreadyout, .hresp, .xfer_read, .xfer_write, .fifo_full, .block_done, .rsp_load,
  .rsp_data, .card_clk, .iface_on_q, .powersave_on_q, .card_slot_select_q, .card_bus_width_q,
  .force_byte_mode_q, .pad_byte_q, .data_timeout_error_q);

//--- testbench/mhc_card_model.sv
// Card-side model: transfer activity, FIFO fill and response load
`timescale 1ns/1ps
module mhc_card_model (
  input  wire         hclk,
  input  wire         hresetn,
  input  wire [1:0]   act,
  input  wire         full,
  input  wire         ld,
  input  wire         bd,
  input  wire [127:0] rsp_val,
  output reg          xfer_read,
  output reg          xfer_write,
  output reg          fifo_full,
  output reg          block_done,
  output reg          rsp_load,
  output wire [127:0] rsp_data
);
  // Response lines carry the inverse outside the load strobe
  assign rsp_data = rsp_load ? rsp_val : ~rsp_val;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {xfer_read, xfer_write, fifo_full, block_done, rsp_load} <= 5'h00;
    end else begin
      xfer_read  <= act[0];
      xfer_write <= act[1];
      fifo_full  <= full;
      block_done <= bd;
      rsp_load   <= ld;
    end
  end
endmodule

//--- testbench/mhc_regs_tb.sv
// Self-checking bench for the card host register bank
`include "mhc_defs.vh"
`timescale 1ns/1ps
module mhc_regs_tb;
  reg          hclk, hresetn, hsel, hwrite, full, ld, bd, rd_dp, v;
  reg  [11:0]  haddr;
  reg  [1:0]   htrans, act;
  reg  [2:0]   hsize;
  reg  [31:0]  hwdata, r;
  reg  [127:0] rsp_val;
  wire [31:0]  hrdata;
  wire         hreadyout, hresp, xfer_read, xfer_write, fifo_full, block_done, rsp_load, card_clk;
  wire         iface_on_q, powersave_on_q, force_byte_mode_q, data_timeout_error_q;
  wire [1:0]   card_slot_select_q, card_bus_width_q;
  wire [7:0]   pad_byte_q;
  wire [127:0] rsp_data;
  logic [31:0] exp_q[$];
  logic [15:0] ct[9] = '{16'h0101, 16'h0300, 16'h0101, 16'h0001, 16'h0200, 16'h0101, 16'h0403, 16'h0c01, 16'h0403};
  int          sh[4] = '{0, 4, 7, 8};
  integer      mismatches, checks_done, i, n;
  mhc_regs #(.TMR_W(24)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .xfer_read, .xfer_write, .fifo_full, .block_done,
    .rsp_load, .rsp_data, .card_clk, .iface_on_q, .powersave_on_q, .card_slot_select_q, .card_bus_width_q,
    .force_byte_mode_q, .pad_byte_q, .data_timeout_error_q);
  mhc_card_model card (.hclk, .hresetn, .act, .full, .ld, .bd, .rsp_val, .xfer_read, .xfer_write, .fifo_full,
    .block_done, .rsp_load, .rsp_data);
  task chk(input [31:0] seen, input [31:0] want);
    checks_done = checks_done + 1;
    if (seen !== want) begin
      mismatches = mismatches + 1;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // One single transfer; each phase held until hready is seen high
  task xfer(input w, input [11:0] a, input [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    rd_dp <= !w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_dp <= 1'b0;
  endtask
  task rd(input [11:0] a, input [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  task per(input integer want);
    while (card_clk !== 1'b0) @(posedge hclk);
    while (card_clk !== 1'b1) @(posedge hclk);
    n = 0;
    while (card_clk !== 1'b0) begin @(posedge hclk); n = n + 1; end
    while (card_clk !== 1'b1) begin @(posedge hclk); n = n + 1; end
    chk(n, want);
  endtask
  task results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge hclk) if (rd_dp) chk(hrdata, exp_q.pop_front());
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // Whole run is under two thousand cycles
  initial begin
    #2000000;
    mismatches = mismatches + 1;
    results;
  end
  initial begin
    {hresetn, hsel, hwrite, full, ld, bd, rd_dp, haddr, htrans, act, hwdata, rsp_val} = '0;
    hsize = 3'b010;
    mismatches = 0;
    checks_done = 0;
    r = $urandom(3);
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (i = 0; i < 4; i = i + 1) rd(i * 4, 32'h0);
    rd(`MHC_OFF_STAT, `MHC_SR_RST);
    rd(12'h038, 32'h0);
    for (i = 0; i < 4; i = i + 1) begin
      r = $urandom;
      xfer(1'b1, `MHC_OFF_MODE, r);
      rd(`MHC_OFF_MODE, r & `MHC_MR_MASK);
      chk(32'(force_byte_mode_q), 32'(r[13]));
      chk(32'(pad_byte_q), {24'h0, {8{r[14]}}});
      xfer(1'b1, `MHC_OFF_BLK, r);
      rd(`MHC_OFF_BLK, r[13] ? r : r & `MHC_BLK_FB_MASK);
      xfer(1'b1, `MHC_OFF_CARD, r);
      rd(`MHC_OFF_CARD, r & `MHC_CARD_MASK);
      chk({28'h0, card_bus_width_q, card_slot_select_q}, {28'h0, r[7:6], r[1:0]});
      xfer(1'b1, `MHC_OFF_DTO, r);
      rd(`MHC_OFF_DTO, r & `MHC_DTO_MASK);
    end
    // Nonzero power-save divider goes in before power save is asked for
    xfer(1'b1, `MHC_OFF_MODE, 32'h0001_0102);
    foreach (ct[i]) begin
      xfer(1'b1, `MHC_OFF_CTRL, {24'h0, ct[i][15:8]});
      @(posedge hclk);
      chk({30'h0, powersave_on_q, iface_on_q}, {30'h0, ct[i][1:0]});
    end
    per(21);
    xfer(1'b1, `MHC_OFF_CTRL, 32'h8);
    per(7);
    xfer(1'b1, `MHC_OFF_MODE, 32'h0000_1803);
    // Read guard, then write guard, each stalled by its own transfer direction
    for (i = 1; i < 3; i = i + 1) begin
      per(8);
      act <= i[1:0];
      full <= 1'b1;
      repeat (3) @(posedge hclk);
      v = card_clk;
      repeat (20) begin @(posedge hclk); chk(32'(card_clk), 32'(v)); end
      full <= 1'b0;
      act <= 2'b00;
    end
    per(8);
    xfer(1'b1, `MHC_OFF_WPMODE, 32'h1);
    xfer(1'b1, `MHC_OFF_MODE, 32'h5);
    rd(`MHC_OFF_MODE, 32'h0000_1803);
    rd(`MHC_OFF_WPSTAT, 32'h0000_0101);
    rsp_val <= {$urandom, $urandom, $urandom, $urandom};
    ld <= 1'b1;
    @(posedge hclk);
    ld <= 1'b0;
    repeat (2) @(posedge hclk);
    for (i = 0; i < 4; i = i + 1) rd(12'h020, rsp_val[127 - 32 * i -: 32]);
    rd(`MHC_OFF_RSP1, rsp_val[95:64]);
    rd(`MHC_OFF_RSP3, rsp_val[31:0]);
    xfer(1'b1, `MHC_OFF_CTRL, 32'h80);
    rd(`MHC_OFF_MODE, 32'h0);
    rd(`MHC_OFF_WPMODE, 32'h0);
    xfer(1'b1, `MHC_OFF_CTRL, 32'h1);
    for (i = 0; i < 4; i = i + 1) begin
      act <= 2'b00;
      xfer(1'b1, `MHC_OFF_DTO, {25'h0, i[2:0], 4'h3});
      act <= 2'b10;
      repeat (2) @(posedge hclk);
      // Block boundary restarts the gap count
      bd <= 1'b1;
      @(posedge hclk);
      bd <= 1'b0;
      repeat ((3 << sh[i]) + 2) @(posedge hclk);
      chk(32'(data_timeout_error_q), 32'h0);
      repeat (4) @(posedge hclk);
      chk(32'(data_timeout_error_q), 32'h1);
      rd(`MHC_OFF_STAT, `MHC_SR_RST | 32'h0040_0000);
    end
    results;
  end
endmodule
